// [hdl/sbcs_pkg.sv]
// Package: constants, types and decode function for the bank command state machine
package sbcs_pkg;

  // ==========================================================
  // Sizes
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int AUTOCLOSE_BIT = 10;
  localparam int CNT_W = 8;
  localparam int STATE_W = 4;

  // ==========================================================
  // Timing, figures in ns, cycles derived from the clock rate
  localparam int CLK_MHZ = 50;
  localparam int PRECHARGE_PERIOD_NS = 15;
  localparam int ACTIVATE_TO_ACCESS_NS = 15;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int ROW_CYCLE_NS = 60;
  localparam int MODE_LOAD_NS = 40;

  // Least times round up, never below one cycle
  function automatic int sbcs_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : sbcs_cycles

  localparam int PRECHARGE_CYC = sbcs_cycles(PRECHARGE_PERIOD_NS);
  localparam int ACT_ACCESS_CYC = sbcs_cycles(ACTIVATE_TO_ACCESS_NS);
  localparam int WRITE_RECOV_CYC = sbcs_cycles(WRITE_RECOVERY_NS);
  localparam int ROW_CYCLE_CYC = sbcs_cycles(ROW_CYCLE_NS);
  localparam int MODE_LOAD_CYC = sbcs_cycles(MODE_LOAD_NS);

  // Double data rate: two words per clock
  localparam int BURST4_CYC = 2;
  localparam int BURST8_CYC = 4;
  // Counter value at which a length-eight burst sits on a four-word boundary
  localparam logic [CNT_W-1:0] BOUNDARY_CNT = CNT_W'(BURST8_CYC - BURST8_CYC / 2);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // Counter load values (count down to zero)
  localparam logic [CNT_W-1:0] LOAD_PRECHARGE = CNT_W'(PRECHARGE_CYC - 1);
  localparam logic [CNT_W-1:0] LOAD_ACT_ACCESS = CNT_W'(ACT_ACCESS_CYC - 1);
  localparam logic [CNT_W-1:0] LOAD_WRITE_RECOV = CNT_W'(WRITE_RECOV_CYC - 1);
  localparam logic [CNT_W-1:0] LOAD_ROW_CYCLE = CNT_W'(ROW_CYCLE_CYC - 1);
  localparam logic [CNT_W-1:0] LOAD_MODE_LOAD = CNT_W'(MODE_LOAD_CYC - 1);
  localparam logic [CNT_W-1:0] LOAD_BURST4 = CNT_W'(BURST4_CYC - 1);
  localparam logic [CNT_W-1:0] LOAD_BURST8 = CNT_W'(BURST8_CYC - 1);

  // ==========================================================
  // Commands and bank states
  typedef enum logic [2:0] {
    CMD_DESELECT = 3'h0,
    CMD_NOP = 3'h1,
    CMD_FETCH = 3'h2,
    CMD_STORE = 3'h3,
    CMD_ROW_OPEN = 3'h4,
    CMD_BANK_CLOSE = 3'h5,
    CMD_RENEW = 3'h6,
    CMD_SETTING_LOAD = 3'h7
  } sbcs_cmd_type;

  typedef enum logic [STATE_W-1:0] {
    ST_IDLE = 4'h0,
    ST_ACTIVATING = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_READ = 4'h3,
    ST_WRITE = 4'h4,
    ST_READ_AP = 4'h5,
    ST_WRITE_AP = 4'h6,
    ST_WR_RECOV = 4'h7,
    ST_WR_RECOV_AP = 4'h8,
    ST_PRECHARGING = 4'h9,
    ST_REFRESHING = 4'hA,
    ST_MODE_ACCESS = 4'hB
  } sbcs_state_type;

  // Pin levels to command
  function automatic sbcs_cmd_type sbcs_decode(input logic csN, input logic rasN,
                                               input logic casN, input logic weN);
    if (csN) begin
      return CMD_DESELECT;
    end
    case ({rasN, casN, weN})
      3'h7: return CMD_NOP;
      3'h5: return CMD_FETCH;
      3'h4: return CMD_STORE;
      3'h3: return CMD_ROW_OPEN;
      3'h2: return CMD_BANK_CLOSE;
      3'h1: return CMD_RENEW;
      default: return CMD_SETTING_LOAD;
    endcase
  endfunction : sbcs_decode

endpackage : sbcs_pkg

// [hdl/sbcs_bank_if.sv]
// Interface: command broadcast to one bank and its state and verdict back
`timescale 1ns/100ps
interface sbcs_bank_if;
  import sbcs_pkg::*;
  sbcs_cmd_type cmd;
  logic hit;
  logic autoClose;
  logic burstLen8;
  logic allIdle;
  sbcs_state_type state;
  logic illegal;

  modport ctrl (output cmd, output hit, output autoClose, output burstLen8, output allIdle,
                input state, input illegal);
  modport bank (input cmd, input hit, input autoClose, input burstLen8, input allIdle,
                output state, output illegal);
endinterface : sbcs_bank_if

// [hdl/sbcs_bank.sv]
// Module: state machine and interval counter of one bank
`timescale 1ns/100ps
module sbcs_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command broadcast
  sbcs_bank_if.bank bus
);
  import sbcs_pkg::*;

  // ==========================================================
  // State and counter
  sbcs_state_type state_r;
  sbcs_state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic illegalNxt;
  logic cntDone;
  logic isIdle;
  logic onBoundary;
  logic [CNT_W-1:0] burstLoad;
  logic aimed;
  sbcs_cmd_type bankCmd;

  assign cntDone = (cnt_r == CNT_ZERO);
  // A command for another bank counts as a no-op here, so running intervals still expire
  assign aimed = bus.hit || (bus.cmd == CMD_RENEW) || (bus.cmd == CMD_SETTING_LOAD);
  assign bankCmd = aimed ? bus.cmd : CMD_NOP;
  assign isIdle = (bankCmd == CMD_DESELECT) || (bankCmd == CMD_NOP);
  assign burstLoad = bus.burstLen8 ? LOAD_BURST8 : LOAD_BURST4;
  // Interrupt only at burst end or on the four-word boundary of a length-eight burst
  assign onBoundary = cntDone || (bus.burstLen8 && (cnt_r == BOUNDARY_CNT));
  assign bus.state = state_r;
  assign bus.illegal = illegalNxt;

  // Next-state decision for the command aimed at this bank
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cntDone ? CNT_ZERO : cnt_r - 8'h01;
    illegalNxt = 1'b0;
    // Refresh and mode load reach every bank; bank-addressed commands only the hit one
    if ((bus.cmd == CMD_RENEW || bus.cmd == CMD_SETTING_LOAD) && state_r != ST_IDLE) begin
      illegalNxt = 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          case (bankCmd)
            CMD_ROW_OPEN: begin
              state_nxt = ST_ACTIVATING;
              cnt_nxt = LOAD_ACT_ACCESS;
            end
            CMD_BANK_CLOSE: begin
              state_nxt = ST_PRECHARGING;
              cnt_nxt = LOAD_PRECHARGE;
            end
            CMD_RENEW: begin
              // Another bank still busy blocks refresh everywhere
              if (bus.allIdle) begin
                state_nxt = ST_REFRESHING;
                cnt_nxt = LOAD_ROW_CYCLE;
              end
            end
            CMD_SETTING_LOAD: begin
              if (bus.allIdle) begin
                state_nxt = ST_MODE_ACCESS;
                cnt_nxt = LOAD_MODE_LOAD;
              end
            end
            CMD_FETCH, CMD_STORE: illegalNxt = 1'b1;
            default: ;
          endcase
        end
        ST_ACTIVE: begin
          case (bankCmd)
            CMD_FETCH: begin
              state_nxt = bus.autoClose ? ST_READ_AP : ST_READ;
              cnt_nxt = burstLoad;
            end
            CMD_STORE: begin
              state_nxt = bus.autoClose ? ST_WRITE_AP : ST_WRITE;
              cnt_nxt = burstLoad;
            end
            CMD_BANK_CLOSE: begin
              state_nxt = ST_PRECHARGING;
              cnt_nxt = LOAD_PRECHARGE;
            end
            CMD_ROW_OPEN: illegalNxt = 1'b1;
            default: ;
          endcase
        end
        ST_READ, ST_WRITE: begin
          if (isIdle) begin
            if (cntDone) begin
              state_nxt = (state_r == ST_READ) ? ST_ACTIVE : ST_WR_RECOV;
              cnt_nxt = (state_r == ST_READ) ? CNT_ZERO : LOAD_WRITE_RECOV;
            end
          end else if (((state_r == ST_READ && bankCmd == CMD_FETCH) ||
                        (state_r == ST_WRITE && bankCmd == CMD_STORE)) && onBoundary) begin
            // Restart the burst, column and auto-close taken afresh
            if (state_r == ST_READ) begin
              state_nxt = bus.autoClose ? ST_READ_AP : ST_READ;
            end else begin
              state_nxt = bus.autoClose ? ST_WRITE_AP : ST_WRITE;
            end
            cnt_nxt = burstLoad;
          end else begin
            illegalNxt = 1'b1;
          end
        end
        ST_READ_AP, ST_WRITE_AP: begin
          if (!isIdle) begin
            illegalNxt = 1'b1;
          end else if (cntDone) begin
            state_nxt = (state_r == ST_READ_AP) ? ST_PRECHARGING : ST_WR_RECOV_AP;
            cnt_nxt = (state_r == ST_READ_AP) ? LOAD_PRECHARGE : LOAD_WRITE_RECOV;
          end
        end
        ST_WR_RECOV: begin
          if (bankCmd == CMD_STORE) begin
            state_nxt = bus.autoClose ? ST_WRITE_AP : ST_WRITE;
            cnt_nxt = burstLoad;
          end else if (!isIdle) begin
            illegalNxt = 1'b1;
          end else if (cntDone) begin
            state_nxt = ST_ACTIVE;
          end
        end
        ST_PRECHARGING: begin
          // A further close is harmless and does not restart the interval
          if (!isIdle && bankCmd != CMD_BANK_CLOSE) begin
            illegalNxt = 1'b1;
          end else if (cntDone) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_ACTIVATING, ST_WR_RECOV_AP, ST_REFRESHING, ST_MODE_ACCESS: begin
          if (!isIdle) begin
            illegalNxt = 1'b1;
          end else if (cntDone) begin
            case (state_r)
              ST_ACTIVATING: state_nxt = ST_ACTIVE;
              ST_WR_RECOV_AP: begin
                state_nxt = ST_PRECHARGING;
                cnt_nxt = LOAD_PRECHARGE;
              end
              default: state_nxt = ST_IDLE;
            endcase
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
    // Illegal command leaves the bank untouched
    if (illegalNxt) begin
      state_nxt = state_r;
      cnt_nxt = cntDone ? CNT_ZERO : cnt_r - 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Interval counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : sbcs_bank

// [hdl/sbcs_top.sv]
// Top: command decode and eight per-bank state machines of a DDR memory device
`timescale 1ns/100ps
module sbcs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins, synchronous to clk
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeStrobeN,
  input wire logic clockEnable,
  input wire logic [sbcs_pkg::BA_W-1:0] unitSelect,
  input wire logic [sbcs_pkg::ADDR_W-1:0] addr,
  // Configuration
  input wire logic burstLen8,
  // Status
  output logic illegalCmd_r,
  output logic [sbcs_pkg::BANKS-1:0] illegalBanks_r,
  output logic selfRefresh_r,
  output logic [sbcs_pkg::BANKS*sbcs_pkg::STATE_W-1:0] bankStates
);
  import sbcs_pkg::*;

  // ==========================================================
  // Decode
  sbcs_cmd_type cmd;
  logic autoClose;
  logic [BANKS-1:0] idleVec;
  logic [BANKS-1:0] illegalVec;
  logic allIdle;

  assign cmd = sbcs_decode(chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN);
  assign autoClose = addr[AUTOCLOSE_BIT];
  assign allIdle = &idleVec;

  // ==========================================================
  // Banks
  sbcs_bank_if bankBus[BANKS]();

  for (genvar i = 0; i < BANKS; i++) begin : gBank
    // Close-all reaches every bank, else only the selected one
    assign bankBus[i].cmd = cmd;
    assign bankBus[i].hit = (unitSelect == BA_W'(i)) ||
                            (cmd == CMD_BANK_CLOSE && autoClose);
    assign bankBus[i].autoClose = autoClose;
    assign bankBus[i].burstLen8 = burstLen8;
    assign bankBus[i].allIdle = allIdle;
    assign idleVec[i] = (bankBus[i].state == ST_IDLE);
    assign illegalVec[i] = bankBus[i].illegal;
    assign bankStates[i*STATE_W +: STATE_W] = bankBus[i].state;

    sbcs_bank uBank (
      .clk(clk),
      .rst_n(rst_n),
      .bus(bankBus[i].bank)
    );
  end

  // ==========================================================
  // Illegal flag, registered so it stands one cycle after the offending edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      illegalCmd_r <= 1'b0;
      illegalBanks_r <= '0;
    end else begin
      illegalCmd_r <= |illegalVec;
      illegalBanks_r <= illegalVec;
    end
  end

  // Self refresh: refresh with clock enable low, held until it rises again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selfRefresh_r <= 1'b0;
    end else if (cmd == CMD_RENEW && !clockEnable && allIdle) begin
      selfRefresh_r <= 1'b1;
    end else if (clockEnable) begin
      selfRefresh_r <= 1'b0;
    end
  end

endmodule : sbcs_top

// [verif/sbcs_ctrl_model.sv]
// Controller model: turns a command code into the four strobe levels
`timescale 1ns/100ps
module sbcs_ctrl_model (
  // Command from the bench
  input wire sbcs_pkg::sbcs_cmd_type cmd,
  // Strobes toward the device
  output logic csN,
  output logic [2:0] pinsN
);
  import sbcs_pkg::*;
  // ==========================================================
  // Encoding
  // Strobe table; the bench keeps legal order unless a refusal is wanted
  always_comb begin
    csN = (cmd == CMD_DESELECT);
    case (cmd)
      CMD_NOP: pinsN = 3'h7;
      CMD_FETCH: pinsN = 3'h5;
      CMD_STORE: pinsN = 3'h4;
      CMD_ROW_OPEN: pinsN = 3'h3;
      CMD_BANK_CLOSE: pinsN = 3'h2;
      CMD_RENEW: pinsN = 3'h1;
      CMD_SETTING_LOAD: pinsN = 3'h0;
      default: pinsN = 3'h2; // Deselected: junk that must not decode
    endcase
  end
endmodule : sbcs_ctrl_model

// [verif/sbcs_top_checker.sv]
// Checker: timing of bank zero transitions and illegal flags at the top ports
`timescale 1ns/100ps
module sbcs_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeStrobeN,
  input wire logic clockEnable,
  input wire logic [sbcs_pkg::BA_W-1:0] unitSelect,
  input wire logic [sbcs_pkg::ADDR_W-1:0] addr,
  input wire logic burstLen8,
  // Status
  input wire logic illegalCmd_r,
  input wire logic [sbcs_pkg::BANKS-1:0] illegalBanks_r,
  input wire logic selfRefresh_r,
  input wire logic [sbcs_pkg::BANKS*sbcs_pkg::STATE_W-1:0] bankStates
);
  import sbcs_pkg::*;
  logic [2:0] pins;
  logic quiet;
  logic sel;
  logic [3:0] st0;
  // ==========================================================
  // Decode helpers, bank zero only to keep the index fixed
  assign pins = {rowStrobeN, columnStrobeN, writeStrobeN};
  assign quiet = chipSelectN || pins == 3'h7;
  assign sel = !chipSelectN && unitSelect == 3'h0;
  assign st0 = bankStates[3:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_row_open_idle: assert property (sel && pins == 3'h3 && st0 == ST_IDLE |=> st0 == ST_ACTIVATING)
    else $error("row open from idle did not start activation");
  a_activate_done: assert property (st0 == ST_ACTIVATING && quiet |=> st0 == ST_ACTIVE)
    else $error("activation did not end in active");
  a_refresh_len: assert property (!chipSelectN && pins == 3'h1 && clockEnable && bankStates == '0
    |=> (st0 == ST_REFRESHING) [*3] ##1 st0 == ST_IDLE) else $error("refresh interval wrong");
  a_mode_len: assert property (!chipSelectN && pins == 3'h0 && bankStates == '0
    |=> (st0 == ST_MODE_ACCESS) [*2] ##1 st0 == ST_IDLE) else $error("mode load interval wrong");
  a_precharge_done: assert property (st0 == ST_PRECHARGING && quiet |=> st0 == ST_IDLE)
    else $error("precharge did not end in idle");
  a_recov_done: assert property (st0 == ST_WR_RECOV && quiet |=> st0 == ST_ACTIVE)
    else $error("write recovery did not end in active");
  a_recov_ap_done: assert property (st0 == ST_WR_RECOV_AP && quiet |=> st0 == ST_PRECHARGING)
    else $error("write recovery with close did not precharge");
  a_ap_refuse: assert property (st0 inside {ST_READ_AP, ST_WRITE_AP} && sel && !quiet
    |=> illegalBanks_r[0]) else $error("command in auto-close burst not flagged");
  a_write_refuse: assert property (st0 == ST_WRITE && sel && pins == 3'h5 |=> illegalBanks_r[0])
    else $error("read during write not flagged");
  a_flag_sum: assert property (illegalCmd_r == (|illegalBanks_r))
    else $error("summary flag disagrees with bank flags");
  a_quiet_clean: assert property (quiet |=> !illegalCmd_r)
    else $error("no-op flagged illegal");
  // Main scenarios reached
  c_read_interrupt: cover property (st0 == ST_READ && sel && pins == 3'h5);
  c_flagged: cover property (illegalCmd_r);
  c_refresh: cover property (st0 == ST_REFRESHING);
endmodule : sbcs_top_checker

// [verif/sdram_bank_command_state_machine_bench.sv]
// Bench: command sequences through the controller model, bank states and flags judged
`timescale 1ns/100ps
module sdram_bank_command_state_machine_bench;
  import sbcs_pkg::*;
  logic clk;
  logic rst_n;
  logic clockEnable;
  logic burstLen8;
  logic [BA_W-1:0] unitSelect;
  logic [ADDR_W-1:0] addr;
  sbcs_cmd_type cmd;
  logic csN;
  logic [2:0] pinsN;
  logic illegalCmd_r;
  logic [BANKS-1:0] illegalBanks_r;
  logic selfRefresh_r;
  logic [BANKS*STATE_W-1:0] bankStates;
  int num_errors = 0;
  int tests_run = 0;
  sbcs_ctrl_model model (.cmd(cmd), .csN(csN), .pinsN(pinsN));
  sbcs_top dut (.clk(clk), .rst_n(rst_n), .chipSelectN(csN), .rowStrobeN(pinsN[2]),
    .columnStrobeN(pinsN[1]), .writeStrobeN(pinsN[0]), .clockEnable(clockEnable),
    .unitSelect(unitSelect), .addr(addr), .burstLen8(burstLen8), .illegalCmd_r(illegalCmd_r),
    .illegalBanks_r(illegalBanks_r), .selfRefresh_r(selfRefresh_r), .bankStates(bankStates));
  // ==========================================================
  // Helpers: drive on falling edge, look 1 ns after the taking edge
  task automatic issue(input sbcs_cmd_type c, input int b, input logic a);
    @(negedge clk);
    cmd = c;
    unitSelect = BA_W'(b);
    addr = a ? 14'h0400 : 14'h0123;
    @(posedge clk);
    #1;
  endtask : issue
  task automatic nop(input int n);
    repeat (n) issue(CMD_NOP, 0, 1'b0);
  endtask : nop
  task automatic chkSt(input int b, input sbcs_state_type e);
    tests_run++;
    if (bankStates[STATE_W*b +: STATE_W] !== e) begin
      num_errors++;
      $display("BAD bank %0d state expected %h seen %h", b, e, bankStates[STATE_W*b +: STATE_W]);
    end
  endtask : chkSt
  task automatic chkFlags(input logic [BANKS-1:0] e);
    tests_run++;
    if (illegalBanks_r !== e || illegalCmd_r !== (|e)) begin
      num_errors++;
      $display("BAD illegal flags expected %h seen %h %b", e, illegalBanks_r, illegalCmd_r);
    end
  endtask : chkFlags
  task automatic summarize();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Scenarios, each leaves bank zero active or idle as the next expects
  task automatic t_walk();
    issue(CMD_ROW_OPEN, 0, 1'b0);
    chkSt(0, ST_ACTIVATING);
    issue(CMD_DESELECT, 0, 1'b0);
    chkSt(0, ST_ACTIVE);
    issue(CMD_FETCH, 0, 1'b0);
    nop(1);
    chkSt(0, ST_READ);
    nop(1);
    chkSt(0, ST_ACTIVE);
  endtask : t_walk
  task automatic t_write();
    issue(CMD_STORE, 0, 1'b0);
    issue(CMD_FETCH, 0, 1'b0);
    chkFlags(8'h01);
    chkSt(0, ST_WRITE);
    nop(1);
    chkSt(0, ST_WR_RECOV);
    issue(CMD_STORE, 0, 1'b0);
    chkSt(0, ST_WRITE);
    chkFlags(8'h00);
    nop(3);
    chkSt(0, ST_ACTIVE);
  endtask : t_write
  task automatic t_read();
    issue(CMD_FETCH, 0, 1'b0);
    issue(CMD_STORE, 0, 1'b0);
    chkFlags(8'h01);
    issue(CMD_FETCH, 0, 1'b0);
    chkFlags(8'h00);
    chkSt(0, ST_READ);
    issue(CMD_FETCH, 0, 1'b0);
    chkFlags(8'h01);
    nop(1);
    chkSt(0, ST_ACTIVE);
    // Length eight: one cycle in is refused, two cycles in is the four-word boundary
    @(negedge clk);
    burstLen8 = 1'b1;
    issue(CMD_FETCH, 0, 1'b0);
    issue(CMD_FETCH, 0, 1'b0);
    chkFlags(8'h01);
    issue(CMD_FETCH, 0, 1'b0);
    chkFlags(8'h00);
    nop(3);
    chkSt(0, ST_READ);
    nop(1);
    chkSt(0, ST_ACTIVE);
    @(negedge clk);
    burstLen8 = 1'b0;
  endtask : t_read
  task automatic t_write_close();
    issue(CMD_STORE, 0, 1'b1);
    chkSt(0, ST_WRITE_AP);
    issue(CMD_ROW_OPEN, 0, 1'b0);
    chkFlags(8'h01);
    nop(1);
    chkSt(0, ST_WR_RECOV_AP);
    nop(1);
    chkSt(0, ST_PRECHARGING);
    nop(1);
    chkSt(0, ST_IDLE);
  endtask : t_write_close
  task automatic t_close();
    issue(CMD_ROW_OPEN, 0, 1'b0);
    issue(CMD_ROW_OPEN, 1, 1'b0);
    chkSt(1, ST_ACTIVATING);
    chkSt(0, ST_ACTIVE);
    issue(CMD_FETCH, 2, 1'b0);
    chkFlags(8'h04);
    nop(1);
    issue(CMD_BANK_CLOSE, 1, 1'b0);
    chkSt(1, ST_PRECHARGING);
    chkSt(0, ST_ACTIVE);
    issue(CMD_BANK_CLOSE, 0, 1'b1);
    chkSt(0, ST_PRECHARGING);
    chkSt(1, ST_IDLE);
    nop(1);
    chkSt(0, ST_IDLE);
  endtask : t_close
  task automatic t_timed();
    issue(CMD_RENEW, 0, 1'b0);
    chkSt(7, ST_REFRESHING);
    issue(CMD_ROW_OPEN, 0, 1'b0);
    chkFlags(8'h01);
    nop(1);
    nop(1);
    chkSt(0, ST_IDLE);
    issue(CMD_ROW_OPEN, 0, 1'b0);
    nop(1);
    issue(CMD_RENEW, 0, 1'b0);
    chkFlags(8'h01);
    chkSt(3, ST_IDLE);
    issue(CMD_BANK_CLOSE, 0, 1'b0);
    nop(1);
    issue(CMD_SETTING_LOAD, 0, 1'b0);
    chkSt(0, ST_MODE_ACCESS);
    nop(2);
    chkSt(0, ST_IDLE);
    clockEnable = 1'b0;
    issue(CMD_RENEW, 0, 1'b0);
    tests_run++;
    if (selfRefresh_r !== 1'b1) begin
      num_errors++;
      $display("BAD selfRefresh_r expected 1 seen %b", selfRefresh_r);
    end
    clockEnable = 1'b1;
    nop(1);
    tests_run++;
    if (selfRefresh_r !== 1'b0) begin
      num_errors++;
      $display("BAD selfRefresh_r expected 0 seen %b", selfRefresh_r);
    end
    nop(4);
  endtask : t_timed
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    clockEnable = 1'b1;
    burstLen8 = 1'b0;
    cmd = CMD_NOP;
    unitSelect = '0;
    addr = '0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_walk();
    t_write();
    t_read();
    t_write_close();
    t_close();
    t_timed();
    summarize();
  end
endmodule : sdram_bank_command_state_machine_bench
bind sbcs_top sbcs_top_checker chk (.clk(clk), .rst_n(rst_n), .chipSelectN(chipSelectN),
  .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN),
  .clockEnable(clockEnable), .unitSelect(unitSelect), .addr(addr), .burstLen8(burstLen8),
  .illegalCmd_r(illegalCmd_r), .illegalBanks_r(illegalBanks_r), .selfRefresh_r(selfRefresh_r),
  .bankStates(bankStates));
